// file: hdl/egt_regs.sv
// e1 global and transmit configuration registers behind an avalon-mm slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module egt_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [10:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [255:0] perf_monitor_bytes,
	input wire logic [1:0] rx_clock_slave,
	input wire logic [1:0] tx_clock_slave,
	input wire logic [1:0] rx_system_clock_in,
	input wire logic [1:0] rx_system_frame_pulse,
	input wire logic [1:0] tx_system_clock_in,
	input wire logic [1:0] tx_system_frame_pulse,
	output logic [1:0] rx_timing_clock,
	output logic [1:0] rx_timing_frame,
	output logic [1:0] tx_timing_clock,
	output logic [1:0] tx_timing_frame,
	output logic rx_multiplex_select,
	output logic tx_multiplex_select,
	input wire logic [13:0] fifo_pointer_distance,
	output logic [1:0] tx_atten_enable,
	output logic [15:0] tx_atten_depth_bits,
	output logic [1:0] tx_atten_bandwidth,
	output logic [1:0] tx_atten_widen,
	output logic [1:0] tx_path_power_down,
	output logic [1:0] line_driver_oe_n,
	output logic [1:0] tx_line_code_select,
	output logic [1:0] driver_fault_monitor_enable,
	output logic [7:0] pulse_template_select,
	output logic [1:0] pulse_template_arbitrary,
	output logic [1:0] template_ram_enable,
	output logic [1:0] template_ram_read,
	output logic [11:0] template_ram_address
);
	// ============================================================
	// bus handshake
	logic ack;
	logic request;
	logic accept_write;
	logic [8:0] index;
	logic [7:0] wbyte;

	assign request = avs_read | avs_write;
	assign index = avs_address[10:2];
	assign wbyte = avs_writedata[7:0];
	// one wait cycle: waitrequest drops on the cycle after a request appears
	assign avs_waitrequest = request & ~ack;
	assign accept_write = avs_write & ack & avs_byteenable[0];

	// acknowledge pulses high for one cycle per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= request & ~ack;
		end
	end

	// true when the index is the given index of the given link
	function automatic logic hit(input logic [8:0] idx, input logic [8:0] base, input int unsigned link);
		hit = (idx == base + (link[0] ? egt_pkg::LINK_STRIDE : 9'h000));
	endfunction : hit

	// ============================================================
	// global registers
	logic [7:0] access_port;
	logic [7:0] access_data;
	logic [7:0] backplane;
	logic [7:0] selected_byte;

	// counter access port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			access_port <= egt_pkg::RST_ACCESS_PORT;
		end else if (accept_write && index == egt_pkg::IDX_ACCESS_PORT) begin
			access_port <= wbyte & egt_pkg::MASK_ACCESS_PORT;
		end
	end

	// link select picks the link, low nibble picks the counter byte
	assign selected_byte = perf_monitor_bytes[{access_port[egt_pkg::POS_LINK_SELECT],
		access_port[3:0], 3'h0} +: 8];

	// access data follows the selected counter byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			access_data <= egt_pkg::RST_ACCESS_DATA;
		end else begin
			access_data <= selected_byte;
		end
	end

	// backplane global configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			backplane <= egt_pkg::RST_BACKPLANE;
		end else if (accept_write && index == egt_pkg::IDX_BACKPLANE) begin
			backplane <= wbyte & egt_pkg::MASK_BACKPLANE;
		end
	end

	assign rx_multiplex_select = backplane[egt_pkg::POS_RX_MUX];
	assign tx_multiplex_select = backplane[egt_pkg::POS_TX_MUX];

	// ============================================================
	// per-link transmit registers
	egt_cfg_if cfg ();
	logic [7:0] jitter_cfg [2];
	logic [7:0] tx_cfg_zero [2];
	logic [7:0] tx_cfg_one [2];
	logic [7:0] template_ram [2];

	assign cfg.rx_shared = backplane[egt_pkg::POS_RX_SHARED];
	assign cfg.tx_shared = backplane[egt_pkg::POS_TX_SHARED];

	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : gen_link
			logic arbitrary;

			// jitter attenuator configuration
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					jitter_cfg[l] <= egt_pkg::RST_JITTER_CFG;
				end else if (accept_write && hit(index, egt_pkg::IDX_JITTER_CFG, l)) begin
					jitter_cfg[l] <= wbyte & egt_pkg::MASK_JITTER_CFG;
				end
			end

			// transmit power and line code
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					tx_cfg_zero[l] <= egt_pkg::RST_TX_CFG_ZERO;
				end else if (accept_write && hit(index, egt_pkg::IDX_TX_CFG_ZERO, l)) begin
					tx_cfg_zero[l] <= wbyte & egt_pkg::MASK_TX_CFG_ZERO;
				end
			end

			// driver monitor, tristate and template code
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					tx_cfg_one[l] <= egt_pkg::RST_TX_CFG_ONE;
				end else if (accept_write && hit(index, egt_pkg::IDX_TX_CFG_ONE, l)) begin
					tx_cfg_one[l] <= wbyte & egt_pkg::MASK_TX_CFG_ONE;
				end
			end

			assign arbitrary = tx_cfg_one[l][3:2] == egt_pkg::ARBITRARY_CODE;

			// template ram control, ignored unless the arbitrary code is chosen
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					template_ram[l] <= egt_pkg::RST_TEMPLATE_RAM;
				end else if (accept_write && arbitrary && hit(index, egt_pkg::IDX_TEMPLATE_RAM, l)) begin
					template_ram[l] <= wbyte;
				end
			end

			// helper configuration
			assign cfg.peak_hold[l] = jitter_cfg[l][egt_pkg::POS_PEAK_HOLD];
			assign cfg.limit_widen[l] = jitter_cfg[l][egt_pkg::POS_LIMIT];
			assign cfg.atten_enable[l] = jitter_cfg[l][egt_pkg::POS_ATTEN_ENABLE];
			assign cfg.atten_depth[l] = jitter_cfg[l][egt_pkg::POS_DEPTH +: 2];
			assign cfg.pointer_distance[l] = fifo_pointer_distance[l*7 +: 7];

			// transmit path controls
			assign tx_atten_enable[l] = jitter_cfg[l][egt_pkg::POS_ATTEN_ENABLE];
			assign tx_atten_bandwidth[l] = jitter_cfg[l][egt_pkg::POS_BANDWIDTH];
			assign tx_atten_depth_bits[l*8 +: 8] = cfg.depth_bits[l];
			assign tx_atten_widen[l] = cfg.widen[l];
			assign tx_path_power_down[l] = tx_cfg_zero[l][egt_pkg::POS_TX_OFF];
			// driver floats on power down or tristate, low enable drives
			assign line_driver_oe_n[l] = tx_cfg_zero[l][egt_pkg::POS_TX_OFF]
				| tx_cfg_one[l][egt_pkg::POS_DRIVER_HIZ];
			assign tx_line_code_select[l] = tx_cfg_zero[l][egt_pkg::POS_LINE_CODE];
			assign driver_fault_monitor_enable[l] = tx_cfg_one[l][egt_pkg::POS_FAULT_MON];
			assign pulse_template_select[l*4 +: 4] = tx_cfg_one[l][3:0];
			assign pulse_template_arbitrary[l] = arbitrary;
			assign template_ram_enable[l] = arbitrary & template_ram[l][egt_pkg::POS_TEMPLATE_RAM_GO];
			assign template_ram_read[l] = template_ram[l][6];
			assign template_ram_address[l*6 +: 6] = template_ram[l][5:0];
		end
	endgenerate

	// ============================================================
	// helpers
	egt_jitter_monitor u_jitter (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(cfg.jitter)
	);

	logic [7:0] timing_out;

	egt_timing_select u_timing (
		.clk(clk),
		.rst_n(rst_n),
		.cfg(cfg.timing),
		.rx_clock_slave(rx_clock_slave),
		.tx_clock_slave(tx_clock_slave),
		.pins({tx_system_frame_pulse, tx_system_clock_in, rx_system_frame_pulse, rx_system_clock_in}),
		.selected(timing_out)
	);

	assign rx_timing_clock = timing_out[1:0];
	assign rx_timing_frame = timing_out[3:2];
	assign tx_timing_clock = timing_out[5:4];
	assign tx_timing_frame = timing_out[7:6];

	// ============================================================
	// read path
	// register value at an index, zero for unmapped indices
	function automatic logic [7:0] read_value(input logic [8:0] idx);
		read_value = 8'h00;
		unique case (idx)
			egt_pkg::IDX_ACCESS_PORT: read_value = access_port;
			egt_pkg::IDX_ACCESS_DATA: read_value = access_data;
			egt_pkg::IDX_BACKPLANE: read_value = backplane;
			egt_pkg::IDX_JITTER_CFG: read_value = jitter_cfg[0];
			egt_pkg::IDX_TX_CFG_ZERO: read_value = tx_cfg_zero[0];
			egt_pkg::IDX_TX_CFG_ONE: read_value = tx_cfg_one[0];
			egt_pkg::IDX_TEMPLATE_RAM: read_value = template_ram[0];
			egt_pkg::IDX_JITTER_STATUS: read_value = {1'b0, cfg.distance_held[0]};
			egt_pkg::IDX_JITTER_CFG + egt_pkg::LINK_STRIDE: read_value = jitter_cfg[1];
			egt_pkg::IDX_TX_CFG_ZERO + egt_pkg::LINK_STRIDE: read_value = tx_cfg_zero[1];
			egt_pkg::IDX_TX_CFG_ONE + egt_pkg::LINK_STRIDE: read_value = tx_cfg_one[1];
			egt_pkg::IDX_TEMPLATE_RAM + egt_pkg::LINK_STRIDE: read_value = template_ram[1];
			egt_pkg::IDX_JITTER_STATUS + egt_pkg::LINK_STRIDE: read_value = {1'b0, cfg.distance_held[1]};
			default: read_value = 8'h00;
		endcase
	endfunction : read_value

	// read data captured in the wait cycle, stands while waitrequest is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack) begin
			avs_readdata <= {24'h00_0000, read_value(index)};
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// bus and counter access
	bus_answer_a: assert property (request && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	counter_select_a: assert property (access_port[egt_pkg::POS_LINK_SELECT] && access_port[3:0] == 4'h5
		##1 $stable(access_port) |-> access_data == $past(perf_monitor_bytes[175:168]))
		else $error("link 2 out-of-frame byte not shown");
	addr_decode_a: assert property (!access_port[egt_pkg::POS_LINK_SELECT]
		##1 $stable(access_port) && $past(rst_n)
		|-> access_data == $past(perf_monitor_bytes[{access_port[3:0], 3'h0} +: 8]))
		else $error("link 1 counter byte not shown");
	data_read_a: assert property (avs_read && !ack && index == egt_pkg::IDX_ACCESS_DATA
		|=> avs_readdata[7:0] == $past(access_data) && avs_readdata[31:8] == 24'h00_0000)
		else $error("access data read wrong");

	// backplane
	rx_mux_a: assert property (accept_write && index == egt_pkg::IDX_BACKPLANE
		|=> rx_multiplex_select == $past(avs_writedata[3]))
		else $error("receive multiplex select not taken");
	tx_mux_a: assert property (accept_write && index == egt_pkg::IDX_BACKPLANE
		|=> tx_multiplex_select == $past(avs_writedata[0]))
		else $error("transmit multiplex select not taken");
	rx_shared_a: assert property (backplane[egt_pkg::POS_RX_SHARED] && &rx_clock_slave
		|-> rx_timing_clock[1] == rx_timing_clock[0] && rx_timing_frame[1] == rx_timing_frame[0])
		else $error("receive timing not shared");
	tx_shared_a: assert property (backplane[egt_pkg::POS_TX_SHARED] && &tx_clock_slave
		|-> tx_timing_clock[1] == tx_timing_clock[0] && tx_timing_frame[1] == tx_timing_frame[0])
		else $error("transmit timing not shared");

	// jitter attenuator
	peak_hold_a: assert property (cfg.peak_hold[0] && $past(cfg.peak_hold[0])
		|-> cfg.distance_held[0] >= $past(cfg.distance_held[0]))
		else $error("held distance decreased");
	bypass_widen_a: assert property (!tx_atten_enable[0] |-> !tx_atten_widen[0])
		else $error("bypassed attenuator widened");
	limit_widen_a: assert property (!jitter_cfg[0][egt_pkg::POS_LIMIT] |-> !tx_atten_widen[0])
		else $error("widened without limit bit");
	depth_code_a: assert property (jitter_cfg[0][2:1] == 2'h1 |-> tx_atten_depth_bits[7:0] == 8'h40)
		else $error("depth code 01 not 64 bits");
	atten_enable_a: assert property (accept_write && index == egt_pkg::IDX_JITTER_CFG
		|=> tx_atten_enable[0] == $past(avs_writedata[egt_pkg::POS_ATTEN_ENABLE]))
		else $error("attenuator enable not taken");
	jitter_bandwidth_a: assert property (accept_write && index == egt_pkg::IDX_JITTER_CFG
		|=> tx_atten_bandwidth[0] == $past(avs_writedata[egt_pkg::POS_BANDWIDTH]))
		else $error("bandwidth select not taken");

	// transmit path
	power_down_a: assert property (tx_path_power_down[0] |-> line_driver_oe_n[0])
		else $error("driver active while powered down");
	power_write_a: assert property (accept_write && index == egt_pkg::IDX_TX_CFG_ZERO
		|=> tx_path_power_down[0] == $past(avs_writedata[egt_pkg::POS_TX_OFF]))
		else $error("power down not taken");
	driver_hiz_a: assert property (tx_cfg_one[0][egt_pkg::POS_DRIVER_HIZ]
		&& !tx_cfg_zero[0][egt_pkg::POS_TX_OFF]
		|-> line_driver_oe_n[0] && !tx_path_power_down[0])
		else $error("tristate affected more than driver");
	line_code_a: assert property (accept_write && index == egt_pkg::IDX_TX_CFG_ZERO
		|=> tx_line_code_select[0] == $past(avs_writedata[egt_pkg::POS_LINE_CODE]))
		else $error("line code select not taken");
	fault_monitor_a: assert property (accept_write && index == egt_pkg::IDX_TX_CFG_ONE
		|=> driver_fault_monitor_enable[0] == $past(avs_writedata[egt_pkg::POS_FAULT_MON]))
		else $error("fault monitor enable not taken");
	template_code_a: assert property (accept_write && index == egt_pkg::IDX_TX_CFG_ONE
		|=> pulse_template_select[3:0] == $past(avs_writedata[3:0])
		&& pulse_template_arbitrary[0] == &$past(avs_writedata[3:2]))
		else $error("template code not taken");
	template_gate_a: assert property (accept_write && index == egt_pkg::IDX_TEMPLATE_RAM
		&& !pulse_template_arbitrary[0] |=> $stable(template_ram[0]))
		else $error("template ram written outside arbitrary code");
	ram_enable_a: assert property (accept_write && index == egt_pkg::IDX_TEMPLATE_RAM
		&& pulse_template_arbitrary[0] |=> template_ram_enable[0] == $past(avs_writedata[7]))
		else $error("template ram enable not taken");
endmodule : egt_regs
`default_nettype wire

// file: hdl/egt_pkg.sv
// constants for the e1 global and transmit configuration register bank
package egt_pkg;
	// ============================================================
	// register indices (byte address is four times the index)
	localparam logic [8:0] IDX_ACCESS_PORT = 9'h00E;
	localparam logic [8:0] IDX_ACCESS_DATA = 9'h00F;
	localparam logic [8:0] IDX_BACKPLANE = 9'h010;
	localparam logic [8:0] IDX_JITTER_CFG = 9'h021;
	localparam logic [8:0] IDX_TX_CFG_ZERO = 9'h022;
	localparam logic [8:0] IDX_TX_CFG_ONE = 9'h023;
	localparam logic [8:0] IDX_TEMPLATE_RAM = 9'h025;
	localparam logic [8:0] IDX_JITTER_STATUS = 9'h038;
	localparam logic [8:0] LINK_STRIDE = 9'h100;
	// ============================================================
	// field positions
	localparam int POS_LINK_SELECT = 4;
	localparam int POS_RX_SHARED = 4;
	localparam int POS_RX_MUX = 3;
	localparam int POS_TX_SHARED = 1;
	localparam int POS_TX_MUX = 0;
	localparam int POS_PEAK_HOLD = 5;
	localparam int POS_LIMIT = 4;
	localparam int POS_ATTEN_ENABLE = 3;
	localparam int POS_DEPTH = 1;
	localparam int POS_BANDWIDTH = 0;
	localparam int POS_TX_OFF = 4;
	localparam int POS_LINE_CODE = 0;
	localparam int POS_FAULT_MON = 5;
	localparam int POS_DRIVER_HIZ = 4;
	localparam int POS_TEMPLATE_RAM_GO = 7;
	// ============================================================
	// reset values
	localparam logic [7:0] RST_ACCESS_PORT = 8'h00;
	localparam logic [7:0] RST_ACCESS_DATA = 8'h00;
	localparam logic [7:0] RST_BACKPLANE = 8'h12;
	localparam logic [7:0] RST_JITTER_CFG = 8'h00;
	localparam logic [7:0] RST_TX_CFG_ZERO = 8'h00;
	localparam logic [7:0] RST_TX_CFG_ONE = 8'h10;
	localparam logic [7:0] RST_TEMPLATE_RAM = 8'h00;
	// ============================================================
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] MASK_ACCESS_PORT = 8'h1F;
	localparam logic [7:0] MASK_BACKPLANE = 8'h1B;
	localparam logic [7:0] MASK_JITTER_CFG = 8'h3F;
	localparam logic [7:0] MASK_TX_CFG_ZERO = 8'h11;
	localparam logic [7:0] MASK_TX_CFG_ONE = 8'h3F;
	// ============================================================
	// jitter attenuator depths and guard windows
	localparam logic [7:0] DEPTH_LONG = 8'h80;
	localparam logic [7:0] DEPTH_MID = 8'h40;
	localparam logic [7:0] DEPTH_SHORT = 8'h20;
	localparam logic [7:0] GUARD_LONG = 8'h04;
	localparam logic [7:0] GUARD_MID = 8'h03;
	localparam logic [7:0] GUARD_SHORT = 8'h02;
	localparam logic [1:0] ARBITRARY_CODE = 2'h3;
endpackage : egt_pkg

// file: hdl/egt_cfg_if.sv
// configuration and status carrier between the register bank and its helpers
`timescale 1ns/1ps
`default_nettype none
interface egt_cfg_if;
	logic rx_shared;
	logic tx_shared;
	logic [1:0] peak_hold;
	logic [1:0] limit_widen;
	logic [1:0] atten_enable;
	logic [1:0][1:0] atten_depth;
	logic [1:0][6:0] pointer_distance;
	logic [6:0] distance_held [2];
	logic [1:0][7:0] depth_bits;
	logic [1:0] widen;
	modport regs (output rx_shared, tx_shared, peak_hold, limit_widen, atten_enable, atten_depth,
		pointer_distance, input distance_held, depth_bits, widen);
	modport timing (input rx_shared, tx_shared);
	modport jitter (input peak_hold, limit_widen, atten_enable, atten_depth, pointer_distance,
		output distance_held, depth_bits, widen);
endinterface : egt_cfg_if
`default_nettype wire

// file: hdl/egt_timing_select.sv
// system clock and frame pulse synchronisers with shared-timing selection
`timescale 1ns/1ps
`default_nettype none
module egt_timing_select (
	input wire logic clk,
	input wire logic rst_n,
	egt_cfg_if.timing cfg,
	input wire logic [1:0] rx_clock_slave,
	input wire logic [1:0] tx_clock_slave,
	input wire logic [7:0] pins,
	output logic [7:0] selected
);
	logic [7:0] stage_one;
	logic [7:0] stage_two;
	logic [7:0] stage_three;
	logic [7:0] filtered;
	logic rx_common;
	logic tx_common;

	// ============================================================
	// three-stage capture, second stage fed to the third and to the filter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_one <= 8'h00;
			stage_two <= 8'h00;
			stage_three <= 8'h00;
		end else begin
			stage_one <= pins;
			stage_two <= stage_one;
			stage_three <= stage_two;
		end
	end

	// a level counts once stages two and three agree, otherwise the old level holds
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filtered <= 8'h00;
		end else begin
			filtered <= (stage_three & ~(stage_two ^ stage_three)) | (filtered & (stage_two ^ stage_three));
		end
	end

	// link 2 follows link 1 only when both links are slaves and sharing is on
	assign rx_common = cfg.rx_shared & (&rx_clock_slave);
	assign tx_common = cfg.tx_shared & (&tx_clock_slave);
	// pin order: rx clock, rx frame, tx clock, tx frame, two bits each
	assign selected[1:0] = rx_common ? {2{filtered[0]}} : filtered[1:0];
	assign selected[3:2] = rx_common ? {2{filtered[2]}} : filtered[3:2];
	assign selected[5:4] = tx_common ? {2{filtered[4]}} : filtered[5:4];
	assign selected[7:6] = tx_common ? {2{filtered[6]}} : filtered[7:6];
endmodule : egt_timing_select
`default_nettype wire

// file: hdl/egt_jitter_monitor.sv
// transmit jitter attenuator pointer monitor, depth decode and guard window
`timescale 1ns/1ps
`default_nettype none
module egt_jitter_monitor (
	input wire logic clk,
	input wire logic rst_n,
	egt_cfg_if.jitter cfg
);
	// depth in bits for a depth code
	function automatic logic [7:0] depth_of(input logic [1:0] code);
		unique case (code)
			2'h0: depth_of = egt_pkg::DEPTH_LONG;
			2'h1: depth_of = egt_pkg::DEPTH_MID;
			2'h2, 2'h3: depth_of = egt_pkg::DEPTH_SHORT;
		endcase
	endfunction : depth_of

	// guard window that goes with the depth
	function automatic logic [7:0] guard_of(input logic [1:0] code);
		unique case (code)
			2'h0: guard_of = egt_pkg::GUARD_LONG;
			2'h1: guard_of = egt_pkg::GUARD_MID;
			2'h2, 2'h3: guard_of = egt_pkg::GUARD_SHORT;
		endcase
	endfunction : guard_of

	genvar l;
	generate
		for (l = 0; l < 2; l++) begin : gen_link
			logic [7:0] distance;
			logic near_edge;
			assign distance = {1'b0, cfg.pointer_distance[l]};
			assign cfg.depth_bits[l] = depth_of(cfg.atten_depth[l]);
			// near overflow or underflow of the fifo
			assign near_edge = (distance <= guard_of(cfg.atten_depth[l]))
				|| (distance >= depth_of(cfg.atten_depth[l]) - guard_of(cfg.atten_depth[l]));
			assign cfg.widen[l] = cfg.atten_enable[l] & cfg.limit_widen[l] & near_edge;

			// live distance, or peak value while holding
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cfg.distance_held[l] <= 7'h00;
				end else if (!cfg.peak_hold[l] || cfg.pointer_distance[l] > cfg.distance_held[l]) begin
					cfg.distance_held[l] <= cfg.pointer_distance[l];
				end
			end
		end
	endgenerate
endmodule : egt_jitter_monitor
`default_nettype wire

// file: verification/egt_host_model.sv
// host model issuing avalon-mm cycles to the register bank
`timescale 1ns/1ps
`default_nettype none
module egt_host_model (
	input wire logic clk,
	output logic [10:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	output logic hung
);
	// ============================================================
	// bus idle at time zero
	initial begin
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable, hung} = '0;
	end
	// one cycle, held until waitrequest is sampled low or 50 clocks have passed
	task automatic xfer(input logic wr, input logic [8:0] idx, input logic [7:0] wd, input logic [3:0] be,
		output logic [7:0] rd);
		int n;
		@(posedge clk);
		avs_address <= {idx, 2'h0};
		avs_read <= ~wr;
		avs_write <= wr;
		avs_writedata <= {24'h000000, wd};
		avs_byteenable <= be;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata[7:0];
		hung <= (n >= 50);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : xfer
endmodule : egt_host_model
`default_nettype wire

// file: verification/egt_regs_tb.sv
// self-checking bench for the e1 configuration register bank
`timescale 1ns/1ps
`default_nettype none
module egt_regs_tb;
	logic clk, rst_n, avs_read, avs_write, avs_waitrequest, hung, rx_multiplex_select, tx_multiplex_select;
	logic [10:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [255:0] perf_monitor_bytes;
	logic [1:0] rx_clock_slave, tx_clock_slave, rx_system_clock_in, rx_system_frame_pulse;
	logic [1:0] tx_system_clock_in, tx_system_frame_pulse, rx_timing_clock, rx_timing_frame;
	logic [1:0] tx_timing_clock, tx_timing_frame, tx_atten_enable, tx_atten_bandwidth, tx_atten_widen;
	logic [1:0] tx_path_power_down, line_driver_oe_n, tx_line_code_select, driver_fault_monitor_enable;
	logic [1:0] pulse_template_arbitrary, template_ram_enable, template_ram_read;
	logic [13:0] fifo_pointer_distance;
	logic [15:0] tx_atten_depth_bits;
	logic [7:0] pulse_template_select, v, d0, d1, dj, db;
	logic [11:0] template_ram_address;
	logic [8:0] a;
	logic [4:0] k;
	int seed, error_cnt, check_count, l;
	localparam logic [6:0] WD [4] = '{7'h02, 7'h03, 7'h1D, 7'h1E};
	localparam logic [3:0] WE = 4'h9;
	egt_regs dut_u (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .perf_monitor_bytes, .rx_clock_slave, .tx_clock_slave,
		.rx_system_clock_in, .rx_system_frame_pulse, .tx_system_clock_in, .tx_system_frame_pulse,
		.rx_timing_clock, .rx_timing_frame, .tx_timing_clock, .tx_timing_frame, .rx_multiplex_select,
		.tx_multiplex_select, .fifo_pointer_distance, .tx_atten_enable, .tx_atten_depth_bits,
		.tx_atten_bandwidth, .tx_atten_widen, .tx_path_power_down, .line_driver_oe_n, .tx_line_code_select,
		.driver_fault_monitor_enable, .pulse_template_select, .pulse_template_arbitrary,
		.template_ram_enable, .template_ram_read, .template_ram_address);
	egt_host_model host_u (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_waitrequest, .hung);
	// ============================================================
	// clock, watchdog and hung bus
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#2000000;
		error_cnt++;
		close_out();
	end
	always @(posedge hung) begin
		error_cnt++;
		close_out();
	end
	// compare, access and verdict helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		logic [7:0] t;
		host_u.xfer(1'b1, idx, d, 4'hF, t);
	endtask : wr
	task automatic rdchk(input logic [8:0] idx, input logic [7:0] e);
		logic [7:0] t;
		host_u.xfer(1'b0, idx, 8'h00, 4'hF, t);
		chk({8'h00, t}, {8'h00, e});
	endtask : rdchk
	function automatic logic [7:0] depth_of(input logic [1:0] c);
		return (c == 2'h0) ? 8'h80 : (c == 2'h1) ? 8'h40 : 8'h20;
	endfunction : depth_of
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out
	// ============================================================
	// main sequence
	initial begin
		seed = 32'hae36;
		error_cnt = 0;
		check_count = 0;
		rst_n = 1'b0;
		rx_clock_slave = 2'h3;
		tx_clock_slave = 2'h3;
		{rx_system_clock_in, rx_system_frame_pulse, tx_system_clock_in, tx_system_frame_pulse} = 8'h00;
		fifo_pointer_distance = 14'h0000;
		for (int i = 0; i < 8; i++) perf_monitor_bytes[i * 32 +: 32] = $random(seed);
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(9'h00E, 8'h00);
		rdchk(9'h00F, perf_monitor_bytes[7:0]);
		rdchk(9'h010, 8'h12);
		rdchk(9'h021, 8'h00);
		rdchk(9'h022, 8'h00);
		rdchk(9'h023, 8'h10);
		chk(line_driver_oe_n, 2'h3);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			k = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : (i == 2) ? 5'h15 : 5'($random(seed));
			wr(9'h00E, {3'h0, k});
			rdchk(9'h00F, perf_monitor_bytes[{k, 3'h0} +: 8]);
		end
		$display("test counters done");
		for (int i = 0; i < 16; i++) begin
			l = i % 2;
			a = l ? 9'h100 : 9'h000;
			d0 = 8'($random(seed));
			d1 = {4'($random(seed)), 4'(i)};
			dj = {3'h0, 2'($random(seed)), 2'(i), 1'($random(seed))};
			db = 8'($random(seed));
			wr(9'h010, db);
			wr(9'h023 + a, 8'h0C);
			wr(9'h025 + a, 8'h00);
			wr(9'h022 + a, d0);
			wr(9'h023 + a, d1);
			v = {1'b1, 7'($random(seed))};
			wr(9'h025 + a, v);
			wr(9'h021 + a, dj);
			rdchk(9'h010, db & 8'h1B);
			rdchk(9'h022 + a, d0 & 8'h11);
			rdchk(9'h023 + a, d1 & 8'h3F);
			rdchk(9'h021 + a, dj);
			chk({rx_multiplex_select, tx_multiplex_select}, {db[3], db[0]});
			chk({tx_path_power_down[l], tx_line_code_select[l], driver_fault_monitor_enable[l], line_driver_oe_n[l]},
				{d0[4], d0[0], d1[5], d0[4] | d1[4]});
			chk({pulse_template_select[l * 4 +: 4], pulse_template_arbitrary[l], template_ram_enable[l]},
				{d1[3:0], &d1[3:2], &d1[3:2]});
			chk({template_ram_read[l], template_ram_address[l * 6 +: 6]}, (&d1[3:2]) ? v[6:0] : 7'h00);
			rdchk(9'h025 + a, (&d1[3:2]) ? v : 8'h00);
			chk({tx_atten_enable[l], tx_atten_bandwidth[l], tx_atten_depth_bits[l * 8 +: 8], tx_atten_widen[l]},
				{dj[3], dj[0], depth_of(dj[2:1]), dj[3] & dj[4]});
		end
		$display("test config done");
		wr(9'h021, 8'h1C);
		for (int i = 0; i < 4; i++) begin
			fifo_pointer_distance[6:0] <= WD[i];
			repeat (4) @(posedge clk);
			chk(tx_atten_widen[0], WE[i]);
		end
		fifo_pointer_distance[6:0] <= 7'h32;
		wr(9'h021, 8'h00);
		rdchk(9'h038, 8'h32);
		wr(9'h021, 8'h20);
		fifo_pointer_distance[6:0] <= 7'h14;
		repeat (4) @(posedge clk);
		rdchk(9'h038, 8'h32);
		fifo_pointer_distance[6:0] <= 7'h3C;
		repeat (4) @(posedge clk);
		rdchk(9'h038, 8'h3C);
		$display("test jitter done");
		{rx_system_clock_in, rx_system_frame_pulse, tx_system_clock_in, tx_system_frame_pulse} <= 8'h55;
		wr(9'h010, 8'h12);
		repeat (6) @(posedge clk);
		chk({rx_timing_clock, rx_timing_frame, tx_timing_clock, tx_timing_frame}, 8'hFF);
		wr(9'h010, 8'h00);
		repeat (6) @(posedge clk);
		chk({rx_timing_clock, rx_timing_frame, tx_timing_clock, tx_timing_frame}, 8'h55);
		host_u.xfer(1'b1, 9'h010, 8'h1B, 4'h0, v);
		rdchk(9'h010, 8'h00);
		rdchk(9'h001, 8'h00);
		$display("test timing done");
		close_out();
	end
endmodule : egt_regs_tb
`default_nettype wire
